// ### pkg/pcfg_pkg.sv
// Constants, types and pin bundles of the passive configuration port.
// Assumes a 10 MHz system clock; every pin is asynchronous to it.
package pcfg_pkg;

  // Scheme select codes.
  localparam logic [1:0] SCH_SERIAL_SYNC = 2'h0;
  localparam logic [1:0] SCH_PAR_SYNC    = 2'h1;
  localparam logic [1:0] SCH_PAR_ASYNC   = 2'h2;
  localparam logic [1:0] SCH_SER_ASYNC   = 2'h3;

  // Timing.
  localparam int CLK_HZ     = 10000000;
  localparam int ABSORB_NS  = 300;
  localparam int ABSORB_CYC =
    (ABSORB_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] ABSORB_CNT = 4'(ABSORB_CYC);

  // Sizes of the configuration image and the initialization run.
  localparam logic [15:0] CFG_BYTES  = 16'h0010;
  localparam logic [7:0]  INIT_TICKS = 8'h0A;
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  // Pin bundle as seen after the synchronisers.
  typedef struct packed {
    logic       cfg_ctrl_n;
    logic [1:0] scheme;
    logic       chain_en_n;
    logic       sel_low_n;
    logic       sel_high;
    logic       config_data_clock;
    logic       ws_n;
    logic       rs_n;
    logic [7:0] data;
    logic       done;
    logic       status_n;
    logic       uclk;
    logic       uclk_en;
  } pcfg_pins_t;

  localparam int PINS_W = 21;
  // Idle levels: strobes and active-low lines high, clocks low.
  localparam logic [PINS_W-1:0] PINS_RST = 21'h133004;

  // Loader states.
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_LOAD  = 6'h02,
    ST_WAIT  = 6'h04,
    ST_INIT  = 6'h08,
    ST_USER  = 6'h10,
    ST_ERROR = 6'h20
  } pcfg_state_t;

endpackage : pcfg_pkg

// ### src/pcfg_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes the bits are independent levels; no bus coherency is given.
`timescale 1ns/1ps
module pcfg_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0]  d_i,
  output logic      [W-1:0]  q_o
);

  logic [W-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          meta_r[g] <= RST_VAL[g];
          q_o[g]    <= RST_VAL[g];
        end
        else
        begin
          meta_r[g] <= d_i[g];
          q_o[g]    <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule : pcfg_sync

// ### src/pcfg_port.sv
// Passive configuration port: loads a configuration image from the pins.
// Assumes the outside party drives the pins and resolves the open-drain
// wires from the output enables; all pin inputs are asynchronous.
`timescale 1ns/1ps
module pcfg_port (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Configuration control and scheme
  input  wire logic                cfg_ctrl_n_i,
  input  wire logic [1:0]          scheme_select_i,
  // Chain and select
  input  wire logic                chain_enable_n_i,
  input  wire logic                select_low_n_i,
  input  wire logic                select_high_i,
  output logic                     chain_enable_out_n_o,
  // Data transfer
  input  wire logic                config_data_clock_i,
  input  wire logic                write_strobe_n_i,
  input  wire logic                read_strobe_n_i,
  input  wire logic [7:0]          data_i,
  output logic      [7:0]          data_o,
  output logic      [7:0]          data_oe_n_o,
  output logic                     ready_not_busy_o,
  // Done and status open-drain lines
  input  wire logic                load_complete_flag_i,
  output logic                     load_complete_flag_o,
  output logic                     load_complete_flag_oe_n_o,
  input  wire logic                status_n_i,
  output logic                     status_n_o,
  output logic                     status_oe_n_o,
  // Initialization clock
  input  wire logic                user_init_clock_i,
  input  wire logic                user_clk_enable_i,
  // Received image and state
  output logic      [7:0]          cfg_byte_o,
  output logic                     cfg_byte_valid_o,
  output logic                     user_mode_o
);

  import pcfg_pkg::*;

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  pcfg_pins_t        pin_raw;
  logic [PINS_W-1:0] pin_sync;
  pcfg_pins_t        pin_q;
  pcfg_pins_t        pin_d_r;

  assign pin_raw.cfg_ctrl_n = cfg_ctrl_n_i;
  assign pin_raw.scheme     = scheme_select_i;
  assign pin_raw.chain_en_n = chain_enable_n_i;
  assign pin_raw.sel_low_n  = select_low_n_i;
  assign pin_raw.sel_high   = select_high_i;
  assign pin_raw.config_data_clock       = config_data_clock_i;
  assign pin_raw.ws_n       = write_strobe_n_i;
  assign pin_raw.rs_n       = read_strobe_n_i;
  assign pin_raw.data       = data_i;
  assign pin_raw.done       = load_complete_flag_i;
  assign pin_raw.status_n   = status_n_i;
  assign pin_raw.uclk       = user_init_clock_i;
  assign pin_raw.uclk_en    = user_clk_enable_i;

  pcfg_sync #(
    .W       (PINS_W),
    .RST_VAL (PINS_RST)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (pin_raw),
    .q_o       (pin_sync)
  );

  assign pin_q = pcfg_pins_t'(pin_sync);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      pin_d_r <= pcfg_pins_t'(PINS_RST);
    else
      pin_d_r <= pin_q;
  end

  // ------------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------------
  pcfg_state_t st_r;
  pcfg_state_t st_nxt;
  logic [7:0]  shift_r;
  logic [2:0]  bit_cnt_r;
  logic [15:0] byte_cnt_r;
  logic [3:0]  busy_cnt_r;
  logic [7:0]  init_cnt_r;

  // Decodes a scheme code into its serial and asynchronous attributes.
  function automatic logic is_serial(input logic [1:0] sch);
    is_serial = (sch == SCH_SERIAL_SYNC) || (sch == SCH_SER_ASYNC);
  endfunction : is_serial

  function automatic logic is_async(input logic [1:0] sch);
    is_async = (sch == SCH_PAR_ASYNC) || (sch == SCH_SER_ASYNC);
  endfunction : is_async

  wire sch_serial = is_serial(pin_q.scheme);
  wire sch_async  = is_async(pin_q.scheme);

  wire ctrl_rise  = pin_q.cfg_ctrl_n & ~pin_d_r.cfg_ctrl_n;
  wire config_data_clock_rise  = pin_q.config_data_clock & ~pin_d_r.config_data_clock;
  wire ws_fall    = ~pin_q.ws_n & pin_d_r.ws_n;
  wire uclk_rise  = pin_q.uclk & ~pin_d_r.uclk;
  wire in_load    = (st_r == ST_LOAD);
  wire busy       = (busy_cnt_r != 4'h0);

  wire enabled    = ~pin_q.chain_en_n;
  wire selected   = ~pin_q.sel_low_n & pin_q.sel_high;

  wire take_sync  = in_load & enabled & ~sch_async & config_data_clock_rise;
  wire strobe_ok  = in_load & enabled & sch_async & selected & ws_fall;
  wire take_async = strobe_ok & ~busy;
  wire overrun    = strobe_ok & busy;
  wire take       = take_sync | take_async;

  wire [7:0] shift_nxt = {pin_q.data[0], shift_r[7:1]};
  wire [7:0] byte_val  = sch_serial ? shift_nxt : pin_q.data;
  wire byte_done = take & (~sch_serial | (bit_cnt_r == LAST_BIT));
  wire last_byte = (byte_cnt_r == CFG_BYTES - 16'h0001);

  wire cfg_active = (st_r == ST_LOAD) | (st_r == ST_WAIT) |
                    (st_r == ST_INIT);
  wire error_hit  = cfg_active & (~pin_q.status_n | overrun);

  wire init_tick  = pin_q.uclk_en ? uclk_rise : 1'b1;
  wire init_last  = (init_cnt_r == INIT_TICKS - 8'h01);

  // ------------------------------------------------------------------
  // Loader state machine
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_RESET:
        if (ctrl_rise)
          st_nxt = ST_LOAD;
      ST_LOAD:
        if (byte_done && last_byte)
          st_nxt = ST_WAIT;
      ST_WAIT:
        if (pin_q.done)
          st_nxt = ST_INIT;
      ST_INIT:
        if (init_tick && init_last)
          st_nxt = ST_USER;
      ST_USER:
        st_nxt = ST_USER;
      ST_ERROR:
        st_nxt = ST_ERROR;
      default:
        st_nxt = ST_RESET;
    endcase
    if (error_hit)
      st_nxt = ST_ERROR;
    if (!pin_q.cfg_ctrl_n)
      st_nxt = ST_RESET;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      st_r <= ST_RESET;
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------------
  // Data capture and counters
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !in_load)
    begin
      shift_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 16'h0000;
    end
    else if (take)
    begin
      shift_r    <= shift_nxt;
      bit_cnt_r  <= sch_serial ? bit_cnt_r + 3'h1 : 3'h0;
      byte_cnt_r <= byte_done ? byte_cnt_r + 16'h0001 : byte_cnt_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      busy_cnt_r <= 4'h0;
    else if (take_async)
      busy_cnt_r <= ABSORB_CNT;
    else if (busy)
      busy_cnt_r <= busy_cnt_r - 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || st_r != ST_INIT)
      init_cnt_r <= 8'h00;
    else if (init_tick)
      init_cnt_r <= init_cnt_r + 8'h01;
  end

  // ------------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------------
  wire rdy_nxt   = (st_nxt == ST_LOAD) & ~busy & ~take_async;
  wire show_rdy  = ~pin_q.rs_n & sch_async & cfg_active;
  logic [7:0] dout_nxt;
  logic [7:0] doe_n_nxt;

  always_comb
  begin
    dout_nxt  = 8'h00;
    doe_n_nxt = 8'hFF;
    if (show_rdy && !sch_serial)
    begin
      dout_nxt[7]  = rdy_nxt;
      doe_n_nxt[7] = 1'b0;
    end
    else if (show_rdy)
    begin
      dout_nxt[0]  = rdy_nxt;
      doe_n_nxt[0] = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ready_not_busy_o          <= 1'b0;
      data_o                    <= 8'h00;
      data_oe_n_o               <= 8'hFF;
      load_complete_flag_o      <= 1'b0;
      load_complete_flag_oe_n_o <= 1'b0;
      status_n_o                <= 1'b0;
      status_oe_n_o             <= 1'b1;
      chain_enable_out_n_o      <= 1'b1;
      user_mode_o               <= 1'b0;
      cfg_byte_o                <= 8'h00;
      cfg_byte_valid_o          <= 1'b0;
    end
    else
    begin
      ready_not_busy_o          <= rdy_nxt;
      data_o                    <= dout_nxt;
      data_oe_n_o               <= doe_n_nxt;
      load_complete_flag_o      <= 1'b0;
      load_complete_flag_oe_n_o <= (st_nxt == ST_WAIT) |
                                   (st_nxt == ST_INIT) |
                                   (st_nxt == ST_USER);
      status_n_o                <= 1'b0;
      status_oe_n_o             <= (st_nxt != ST_ERROR);
      chain_enable_out_n_o      <= (st_nxt != ST_USER);
      user_mode_o               <= (st_nxt == ST_USER);
      cfg_byte_o                <= byte_done ? byte_val : cfg_byte_o;
      cfg_byte_valid_o          <= byte_done;
    end
  end

endmodule : pcfg_port

// ### test/pcfg_checker.sv
// Concurrent checks on the pins of the passive configuration port.
// Assumes it is bound into pcfg_port and sees only that module's ports.
`timescale 1ns/1ps
module pcfg_checker (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Pins into the port
  input  wire logic       cfg_ctrl_n_i,
  input  wire logic [1:0] scheme_select_i,
  input  wire logic       chain_enable_n_i,
  input  wire logic       select_low_n_i,
  input  wire logic       select_high_i,
  input  wire logic       read_strobe_n_i,
  // Pins out of the port
  input  wire logic       chain_enable_out_n_o,
  input  wire logic [7:0] data_oe_n_o,
  input  wire logic       ready_not_busy_o,
  input  wire logic       load_complete_flag_oe_n_o,
  input  wire logic       status_oe_n_o,
  input  wire logic       cfg_byte_valid_o,
  input  wire logic       user_mode_o
);
  import pcfg_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------------------------------
  // Pin relations
  // ----------------------------------------------------------------
  chk_ctrl_done: assert property (
    !cfg_ctrl_n_i [*5] |=> !load_complete_flag_oe_n_o)
    else $error("done line not driven while held in reset");
  chk_chain_out: assert property (
    chain_enable_out_n_o != user_mode_o)
    else $error("chain output does not follow user mode");
  chk_user_done: assert property (
    user_mode_o |-> load_complete_flag_oe_n_o)
    else $error("done line driven in user mode");
  chk_user_keep: assert property (
    $fell(user_mode_o) |-> !$past(cfg_ctrl_n_i, 3)
      || !$past(cfg_ctrl_n_i, 4))
    else $error("user mode left without a restart");
  chk_busy_hold: assert property (
    $fell(ready_not_busy_o) |-> !ready_not_busy_o [*3])
    else $error("busy shorter than the absorb time");
  chk_rd_par: assert property (
    !data_oe_n_o[7] |-> scheme_select_i == SCH_PAR_ASYNC
      && !$past(read_strobe_n_i, 3))
    else $error("bit seven driven without a read strobe");
  chk_rd_ser: assert property (
    !data_oe_n_o[0] |-> scheme_select_i == SCH_SER_ASYNC
      && !$past(read_strobe_n_i, 3))
    else $error("bit zero driven without a read strobe");
  chk_bus_quiet: assert property (
    &data_oe_n_o[6:1])
    else $error("middle data bits driven");
  chk_chain_gate: assert property (
    cfg_byte_valid_o |-> !$past(chain_enable_n_i, 3))
    else $error("byte taken with chain enable high");
  chk_sel_gate: assert property (
    cfg_byte_valid_o && scheme_select_i[1] |->
      !$past(select_low_n_i, 3) && $past(select_high_i, 3))
    else $error("byte taken while not selected");
  chk_err_user: assert property (
    !status_oe_n_o |-> !user_mode_o)
    else $error("status driven in user mode");

  cov_byte: cover property (cfg_byte_valid_o);
  cov_user: cover property ($rose(user_mode_o));
  cov_err: cover property ($fell(status_oe_n_o));
endmodule : pcfg_checker

// ### test/pcfg_host.sv
// Host model: a processor feeding configuration units to the port.
// Assumes the bench resolves the shared data bus against the device.
`timescale 1ns/1ps
module pcfg_host (
  // Clock and handshake
  input  wire logic       clk_i,
  input  wire logic       rdy_i,
  // Pins driven by the host
  output logic            config_data_clock_o,
  output logic            ws_n_o,
  output logic [7:0]      dat_o
);
  initial
  begin
    config_data_clock_o = 1'b0;
    ws_n_o = 1'b1;
    dat_o  = 8'h00;
  end

  task automatic unit(input logic [7:0] v, input logic as, input int n);
    @(posedge clk_i);
    dat_o  <= v;
    ws_n_o <= ~as;
    repeat (n) @(posedge clk_i);
    config_data_clock_o <= ~as;
    ws_n_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    config_data_clock_o <= 1'b0;
  endtask : unit

  task automatic send(input logic [7:0] v, input logic [1:0] s,
                      input int n, output logic ok);
    int i;
    int k;
    ok = 1'b1;
    for (i = 0; i < ((s[0] ^ s[1]) ? 1 : 8); i++)
    begin
      @(negedge clk_i);
      for (k = 0; k < 40 && s[1] && rdy_i !== 1'b1; k++)
        @(negedge clk_i);
      ok = ok & (k < 40);
      unit((s[0] ^ s[1]) ? v : {~v[7:1], v[i]}, s[1], n);
    end
    // With n above one, a released bus must not keep showing the last value.
    if (n > 1)
    begin
      @(posedge clk_i);
      dat_o <= ~dat_o;
    end
  endtask : send
endmodule : pcfg_host

// ### test/testbench.sv
// Self-checking bench for the passive configuration port.
// Assumes pcfg_pkg is compiled first; the host model drives transfers.
`timescale 1ns/1ps
module testbench;
  import pcfg_pkg::*;
  logic       clk_i, sys_rst_i, ctrl_n, chain_n, sel_hi, rs_n;
  logic       uclk, uclk_en, hold_done, hold_stat, ok;
  logic       ceo_n, rdy, done_o, done_oe_n, st_o, st_oe_n, byte_v, umode;
  logic [1:0] sch;
  logic [7:0] d_o, d_oe_n, byte_o, v, exp_q[$];
  wire        config_data_clock, ws_n;
  wire  [7:0] hdat;
  int         n_errors, cmp_count, seed, k;
  // Open-drain lines with pull-ups, and the shared data bus.
  wire        done_w = (done_oe_n | done_o) & ~hold_done;
  wire        stat_w = (st_oe_n | st_o) & ~hold_stat;
  wire  [7:0] bus = (d_oe_n & hdat) | (~d_oe_n & d_o);

  always #50 clk_i = ~clk_i;
  always #400.3 uclk = ~uclk;

  // unused low select tied to its active level
  pcfg_port dut (
    .clk_i, .sys_rst_i, .cfg_ctrl_n_i(ctrl_n), .scheme_select_i(sch),
    .chain_enable_n_i(chain_n), .select_low_n_i(1'b0),
    .select_high_i(sel_hi), .chain_enable_out_n_o(ceo_n),
    .config_data_clock_i(config_data_clock), .write_strobe_n_i(ws_n),
    .read_strobe_n_i(rs_n), .data_i(bus), .data_o(d_o),
    .data_oe_n_o(d_oe_n), .ready_not_busy_o(rdy),
    .load_complete_flag_i(done_w), .load_complete_flag_o(done_o),
    .load_complete_flag_oe_n_o(done_oe_n), .status_n_i(stat_w),
    .status_n_o(st_o), .status_oe_n_o(st_oe_n),
    .user_init_clock_i(uclk), .user_clk_enable_i(uclk_en),
    .cfg_byte_o(byte_o), .cfg_byte_valid_o(byte_v), .user_mode_o(umode));

  pcfg_host host (.clk_i, .rdy_i(rdy), .config_data_clock_o(config_data_clock), .ws_n_o(ws_n),
                  .dat_o(hdat));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    n_errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail
  task automatic chk1(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp)
      fail(m);
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
      fail("received byte differs");
  endtask : chk8
  task automatic close_out;
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  always @(negedge clk_i)
    if (byte_v === 1'b1)
    begin
      if (exp_q.size() == 0)
        fail("byte without a send");
      else
        chk8(byte_o, exp_q.pop_front());
    end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic put(input logic [7:0] b, input int n);
    host.send(b, sch, n, ok);
    chk1(ok, 1'b1, "ready never came");
    if (!ok)
      close_out;
  endtask : put
  task automatic restart(input logic [1:0] s);
    @(posedge clk_i);
    ctrl_n <= 1'b0;
    sch    <= s;
    repeat (5) @(negedge clk_i);
    chk1(done_oe_n, 1'b0, "done not driven in reset");
    chk1(st_oe_n, 1'b1, "status driven in reset");
    @(posedge clk_i);
    ctrl_n <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask : restart
  task automatic rd_stat(input int b);
    @(posedge clk_i);
    rs_n <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk1(d_oe_n[b], 1'b0, "ready not on the bus");
    chk1(bus[b], 1'b1, "idle port not ready");
    @(posedge clk_i);
    rs_n <= 1'b1;
    repeat (4) @(negedge clk_i);
    chk1(d_oe_n[b], 1'b1, "bus not released");
  endtask : rd_stat
  task automatic load(input logic [1:0] s);
    int i;
    int n;
    restart(s);
    uclk_en <= s[0] & s[1];
    chain_n <= ~s[1];
    sel_hi  <= ~s[1];
    put(8'h5A, 4);
    // enable and selects held active from here on
    chain_n   <= 1'b0;
    sel_hi    <= 1'b1;
    hold_done <= 1'b1;
    for (i = 0; i < CFG_BYTES; i++)
    begin
      v = 8'($random(seed));
      exp_q.push_back(v);
      put(v, 4);
      if (i == 5 && s[1])
        rd_stat(s[0] ? 0 : 7);
    end
    repeat (30) @(negedge clk_i);
    chk1(done_oe_n, 1'b1, "done not released");
    chk1(umode, 1'b0, "init ran under done low");
    @(posedge clk_i);
    hold_done <= 1'b0;
    for (n = 0; n < 200 && umode !== 1'b1; n++)
      @(negedge clk_i);
    chk1(n < 200, 1'b1, "user mode never came");
    if (n == 200)
      close_out;
    chk1(n >= int'(INIT_TICKS) * 6, s == 2'h3, "init clock");
    chk1(ceo_n, 1'b0, "chain output not low");
    @(posedge clk_i);
    hold_done <= 1'b1;
    hold_stat <= 1'b1;
    repeat (12) @(negedge clk_i);
    chk1(umode, 1'b1, "user mode lost");
    @(posedge clk_i);
    hold_done <= 1'b0;
    hold_stat <= 1'b0;
  endtask : load

  initial
  begin
    clk_i = 1'b0;
    uclk = 1'b0;
    sys_rst_i = 1'b1;
    {ctrl_n, chain_n, sel_hi, rs_n} = 4'hF;
    {uclk_en, hold_done, hold_stat} = 3'h0;
    sch = 2'h0;
    seed = 69143;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      load(2'(k));
      $display("load test with scheme %0d ended", k);
    end
    restart(SCH_PAR_ASYNC);
    v = 8'($random(seed));
    exp_q.push_back(v);
    put(v, 1);
    put(~v, 1);
    repeat (10) @(negedge clk_i);
    chk1(st_oe_n, 1'b0, "overrun not flagged");
    restart(SCH_SERIAL_SYNC);
    hold_stat <= 1'b1;
    repeat (4) @(posedge clk_i);
    hold_stat <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk1(st_oe_n, 1'b0, "status low not flagged");
    chk1(exp_q.size() == 0, 1'b1, "bytes never received");
    $display("error tests ended");
    close_out;
  end
endmodule : testbench

bind pcfg_port pcfg_checker u_chk (
  .clk_i, .sys_rst_i, .cfg_ctrl_n_i, .scheme_select_i, .chain_enable_n_i,
  .select_low_n_i, .select_high_i, .read_strobe_n_i,
  .chain_enable_out_n_o, .data_oe_n_o, .ready_not_busy_o,
  .load_complete_flag_oe_n_o, .status_oe_n_o, .cfg_byte_valid_o,
  .user_mode_o);
